// ---- include/rca_cfg.svh ----
`ifndef RCA_CFG_SVH
`define RCA_CFG_SVH

// Bus address, arbitrary value
`define RCA_I2C_ADDR 7'h2a

// Register offsets
`define RCA_OFS_INT_EN  8'h01
`define RCA_OFS_TK_SEC  8'h06
`define RCA_OFS_TK_MIN  8'h07
`define RCA_OFS_TK_HRS  8'h08
`define RCA_OFS_WEEKDAY 8'h09
`define RCA_OFS_DATE    8'h0a
`define RCA_OFS_MONTH   8'h0b
`define RCA_OFS_YEAR    8'h0c
`define RCA_OFS_A1_SEC  8'h0d
`define RCA_OFS_A1_MIN  8'h0e
`define RCA_OFS_A1_HRS  8'h0f
`define RCA_OFS_A1_DD   8'h10
`define RCA_OFS_A1_MON  8'h11
`define RCA_OFS_A1_YEAR 8'h12

// Bit positions
`define RCA_BIT_A1_IE   0
`define RCA_BIT_MASK    7
`define RCA_BIT_DYDT    6
`define RCA_BIT_YR_MASK 6

// Compared value fields
`define RCA_FLD_SEC     8'h7f
`define RCA_FLD_HRS     8'h1f
`define RCA_FLD_DATE    8'h3f
`define RCA_FLD_MONTH   8'h1f
`define RCA_FLD_WEEKDAY 8'h07
`define RCA_FLD_YEAR    8'hff

// Writable bits
`define RCA_WM_INT_EN   8'h01
`define RCA_WM_MONTH    8'h9f
`define RCA_WM_A1_HRS   8'h9f
`define RCA_WM_A1_MON   8'hdf
`define RCA_WM_FULL     8'hff

// Reset values
`define RCA_RST_WEEKDAY 8'h01
`define RCA_RST_DATE    8'h01
`define RCA_RST_MONTH   8'h01
`define RCA_RST_ZERO    8'h00

// Serial framing
`define RCA_ACK_SLOT    4'h8

`endif

// ---- include/rca_pkg.sv ----
`default_nettype none

package rca_pkg;

  // Serial link phases
  typedef enum logic [2:0] {
    RCA_LINK_IDLE    = 3'h0,
    RCA_LINK_DEVADDR = 3'h1,
    RCA_LINK_POINTER = 3'h2,
    RCA_LINK_WRITE   = 3'h3,
    RCA_LINK_READ    = 3'h4
  } rca_link_state_type;

  // Request passed from link to core
  typedef struct packed {
    logic       write_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
  } rca_req_type;

endpackage

`default_nettype wire

// ---- include/rca_sync_if.sv ----
`default_nettype none

interface rca_sync_if;
  logic async_in;
  logic sync_out;

  modport sync_side (input async_in, output sync_out);
  modport user_side (output async_in, input sync_out);
endinterface

`default_nettype wire

// ---- design/rca_sync2.sv ----
`default_nettype none

module rca_sync2 (
  input  wire logic   clk,
  input  wire logic   rst_n,
  rca_sync_if.sync_side port
);

  logic meta_reg;
  logic stable_reg;

  // Two-stage level synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg   <= 1'b0;
      stable_reg <= 1'b0;
    end else begin
      meta_reg   <= port.async_in;
      stable_reg <= meta_reg;
    end
  end

  assign port.sync_out = stable_reg;

endmodule

`default_nettype wire

// ---- design/rca_top.sv ----
`include "rca_cfg.svh"
`default_nettype none

////////////////////////////////////////////////////////////////////////

// Operation
// - Alarm registers 0Dh-12h hold comparison targets
// - Enable bit gates match onto interrupt
// - Bit 7, month bit 6 mask fields
// - All masks clear: every field must match
// - Masks give per-second, second, minute rates
// - Hours, minutes, seconds match ignores select
// - Year masked: month, date, time match
// - No masks: year through seconds match
// - Select 0 compares date of month
// - Select 1 compares day of week
// - Select bit 6, value bits 0-5
// - Alarm seconds: mask, tens, units, reset 0
// - Alarm minutes: mask, tens, units, reset 0
// - Alarm hours: mask, tens bit 4, units
// - Alarm month: masks 7/6, tens, units
module rca_top (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       i2c_scl,
  input  wire logic       i2c_sda_in,
  output logic            i2c_sda_out,
  output logic            i2c_sda_oe,
  input  wire logic       sec_tick,
  input  wire logic [7:0] tk_seconds,
  input  wire logic [7:0] tk_minutes,
  input  wire logic [7:0] tk_hours,
  output logic            alarm1_event,
  output logic            int_n
);

  ////////////////////////////////////////////////////////////////////////

  // Core-domain register file
  logic [7:0] int_enable_reg;
  logic [7:0] calendar_weekday_reg;
  logic [7:0] calendar_date_reg;
  logic [7:0] calendar_month_century_reg;
  logic [7:0] calendar_year_reg;
  logic [7:0] first_alarm_seconds_reg;
  logic [7:0] first_alarm_minutes_reg;
  logic [7:0] first_alarm_hours_reg;
  logic [7:0] first_alarm_daydate_reg;
  logic [7:0] first_alarm_month_reg;
  logic [7:0] first_alarm_year_reg;

  // Core-domain handshake and alarm state
  logic       req_seen_reg;
  logic       ack_tog_reg;
  logic [7:0] read_data_reg;
  logic       tick_delay_reg;
  logic       alarm1_event_reg;
  logic       int_n_reg;
  logic       req_event;
  logic       host_write;
  logic       alarm_match;

  // Link-domain state
  rca_pkg::rca_link_state_type link_state_reg;
  rca_pkg::rca_req_type        req_reg;
  logic [3:0] bit_count_reg;
  logic [7:0] shift_in_reg;
  logic [7:0] pointer_reg;
  logic [7:0] tx_byte_reg;
  logic [7:0] read_hold_reg;
  logic       req_tog_reg;
  logic       start_tog_reg;
  logic       start_seen_reg;
  logic       ack_seen_reg;
  logic       sda_out_reg;
  logic       sda_oe_reg;
  logic       start_pending;
  logic       addr_hit;

  ////////////////////////////////////////////////////////////////////////

  // Toggle crossings in both directions
  rca_sync_if req_sync ();
  rca_sync_if ack_sync ();

  assign req_sync.async_in = req_tog_reg;
  assign ack_sync.async_in = ack_tog_reg;

  rca_sync2 u_req_sync (
    .clk   (core_clk),
    .rst_n (rst_n),
    .port  (req_sync)
  );

  rca_sync2 u_ack_sync (
    .clk   (i2c_scl),
    .rst_n (rst_n),
    .port  (ack_sync)
  );

  ////////////////////////////////////////////////////////////////////////

  // Start condition: data falls while clock high
  always_ff @(negedge i2c_sda_in or negedge rst_n) begin
    if (!rst_n) begin
      start_tog_reg <= 1'b0;
    end else if (i2c_scl) begin
      start_tog_reg <= ~start_tog_reg;
    end
  end

  assign start_pending = start_tog_reg != start_seen_reg;
  assign addr_hit      = shift_in_reg[7:1] == `RCA_I2C_ADDR;

  // Link sampling, framing and request issue
  always_ff @(posedge i2c_scl or negedge rst_n) begin
    if (!rst_n) begin
      link_state_reg <= rca_pkg::RCA_LINK_IDLE;
      bit_count_reg  <= 4'h0;
      shift_in_reg   <= 8'h00;
      pointer_reg    <= 8'h00;
      start_seen_reg <= 1'b0;
      req_reg        <= '0;
      req_tog_reg    <= 1'b0;
    end else if (start_pending) begin
      // First address bit arrives with the start
      start_seen_reg <= start_tog_reg;
      link_state_reg <= rca_pkg::RCA_LINK_DEVADDR;
      bit_count_reg  <= 4'h1;
      shift_in_reg   <= {7'h00, i2c_sda_in};
    end else if (bit_count_reg == `RCA_ACK_SLOT) begin
      bit_count_reg <= 4'h0;
      case (link_state_reg)
        rca_pkg::RCA_LINK_DEVADDR: begin
          if (!addr_hit) begin
            link_state_reg <= rca_pkg::RCA_LINK_IDLE;
          end else if (shift_in_reg[0]) begin
            // Byte at pointer is already held; prefetch next
            link_state_reg   <= rca_pkg::RCA_LINK_READ;
            pointer_reg      <= pointer_reg + 8'h01;
            req_reg.write_en <= 1'b0;
            req_reg.rd_addr  <= pointer_reg + 8'h01;
            req_tog_reg      <= ~req_tog_reg;
          end else begin
            link_state_reg <= rca_pkg::RCA_LINK_POINTER;
          end
        end
        rca_pkg::RCA_LINK_POINTER: begin
          link_state_reg   <= rca_pkg::RCA_LINK_WRITE;
          pointer_reg      <= shift_in_reg;
          req_reg.write_en <= 1'b0;
          req_reg.rd_addr  <= shift_in_reg;
          req_tog_reg      <= ~req_tog_reg;
        end
        rca_pkg::RCA_LINK_WRITE: begin
          // Data byte goes to pointer, pointer advances
          pointer_reg      <= pointer_reg + 8'h01;
          req_reg.write_en <= 1'b1;
          req_reg.wr_addr  <= pointer_reg;
          req_reg.wr_data  <= shift_in_reg;
          req_reg.rd_addr  <= pointer_reg + 8'h01;
          req_tog_reg      <= ~req_tog_reg;
        end
        rca_pkg::RCA_LINK_READ: begin
          if (i2c_sda_in) begin
            link_state_reg <= rca_pkg::RCA_LINK_IDLE;
          end else begin
            pointer_reg      <= pointer_reg + 8'h01;
            req_reg.write_en <= 1'b0;
            req_reg.rd_addr  <= pointer_reg + 8'h01;
            req_tog_reg      <= ~req_tog_reg;
          end
        end
        default: begin
          link_state_reg <= rca_pkg::RCA_LINK_IDLE;
        end
      endcase
    end else if (link_state_reg != rca_pkg::RCA_LINK_IDLE) begin
      shift_in_reg  <= {shift_in_reg[6:0], i2c_sda_in};
      bit_count_reg <= bit_count_reg + 4'h1;
    end
  end

  // Read answers land in the hold byte
  always_ff @(posedge i2c_scl or negedge rst_n) begin
    if (!rst_n) begin
      ack_seen_reg  <= 1'b0;
      read_hold_reg <= 8'h00;
    end else begin
      ack_seen_reg <= ack_sync.sync_out;
      if (ack_sync.sync_out != ack_seen_reg) begin
        read_hold_reg <= read_data_reg;
      end
    end
  end

  // Data line driven on falling clock, open drain
  always_ff @(negedge i2c_scl or negedge rst_n) begin
    if (!rst_n) begin
      sda_out_reg <= 1'b0;
      sda_oe_reg  <= 1'b0;
      tx_byte_reg <= 8'h00;
    end else if (start_pending) begin
      sda_oe_reg <= 1'b0;
    end else begin
      sda_out_reg <= 1'b0;
      case (link_state_reg)
        rca_pkg::RCA_LINK_DEVADDR: begin
          sda_oe_reg <= (bit_count_reg == `RCA_ACK_SLOT) && addr_hit;
        end
        rca_pkg::RCA_LINK_POINTER,
        rca_pkg::RCA_LINK_WRITE: begin
          sda_oe_reg <= bit_count_reg == `RCA_ACK_SLOT;
        end
        rca_pkg::RCA_LINK_READ: begin
          if (bit_count_reg == 4'h0) begin
            tx_byte_reg <= {read_hold_reg[6:0], 1'b0};
            sda_oe_reg  <= ~read_hold_reg[7];
          end else if (bit_count_reg == `RCA_ACK_SLOT) begin
            sda_oe_reg <= 1'b0;
          end else begin
            tx_byte_reg <= {tx_byte_reg[6:0], 1'b0};
            sda_oe_reg  <= ~tx_byte_reg[7];
          end
        end
        default: begin
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////

  // Request edge seen in core domain
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_seen_reg <= 1'b0;
    end else begin
      req_seen_reg <= req_sync.sync_out;
    end
  end

  assign req_event  = req_sync.sync_out != req_seen_reg;
  assign host_write = req_event && req_reg.write_en;

  // Calendar and enable registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_enable_reg             <= `RCA_RST_ZERO;
      calendar_weekday_reg       <= `RCA_RST_WEEKDAY;
      calendar_date_reg          <= `RCA_RST_DATE;
      calendar_month_century_reg <= `RCA_RST_MONTH;
      calendar_year_reg          <= `RCA_RST_ZERO;
    end else if (host_write) begin
      case (req_reg.wr_addr)
        `RCA_OFS_INT_EN:  int_enable_reg <= req_reg.wr_data & `RCA_WM_INT_EN;
        `RCA_OFS_WEEKDAY: calendar_weekday_reg <= req_reg.wr_data & `RCA_FLD_WEEKDAY;
        `RCA_OFS_DATE:    calendar_date_reg <= req_reg.wr_data & `RCA_FLD_DATE;
        `RCA_OFS_MONTH:   calendar_month_century_reg <= req_reg.wr_data & `RCA_WM_MONTH;
        `RCA_OFS_YEAR:    calendar_year_reg <= req_reg.wr_data;
        default: begin
        end
      endcase
    end
  end

  // Alarm target registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_alarm_seconds_reg <= `RCA_RST_ZERO;
      first_alarm_minutes_reg <= `RCA_RST_ZERO;
      first_alarm_hours_reg   <= `RCA_RST_ZERO;
      first_alarm_daydate_reg <= `RCA_RST_ZERO;
      first_alarm_month_reg   <= `RCA_RST_ZERO;
      first_alarm_year_reg    <= `RCA_RST_ZERO;
    end else if (host_write) begin
      case (req_reg.wr_addr)
        `RCA_OFS_A1_SEC:  first_alarm_seconds_reg <= req_reg.wr_data & `RCA_WM_FULL;
        `RCA_OFS_A1_MIN:  first_alarm_minutes_reg <= req_reg.wr_data & `RCA_WM_FULL;
        `RCA_OFS_A1_HRS:  first_alarm_hours_reg <= req_reg.wr_data & `RCA_WM_A1_HRS;
        `RCA_OFS_A1_DD:   first_alarm_daydate_reg <= req_reg.wr_data & `RCA_WM_FULL;
        `RCA_OFS_A1_MON:  first_alarm_month_reg <= req_reg.wr_data & `RCA_WM_A1_MON;
        `RCA_OFS_A1_YEAR: first_alarm_year_reg <= req_reg.wr_data;
        default: begin
        end
      endcase
    end
  end

  // Register read selection
  function automatic logic [7:0] reg_read(input logic [7:0] addr);
    logic [7:0] value;
    value = 8'h00;
    case (addr)
      `RCA_OFS_INT_EN:  value = int_enable_reg;
      `RCA_OFS_TK_SEC:  value = tk_seconds & `RCA_FLD_SEC;
      `RCA_OFS_TK_MIN:  value = tk_minutes & `RCA_FLD_SEC;
      `RCA_OFS_TK_HRS:  value = tk_hours & `RCA_FLD_HRS;
      `RCA_OFS_WEEKDAY: value = calendar_weekday_reg;
      `RCA_OFS_DATE:    value = calendar_date_reg;
      `RCA_OFS_MONTH:   value = calendar_month_century_reg;
      `RCA_OFS_YEAR:    value = calendar_year_reg;
      `RCA_OFS_A1_SEC:  value = first_alarm_seconds_reg;
      `RCA_OFS_A1_MIN:  value = first_alarm_minutes_reg;
      `RCA_OFS_A1_HRS:  value = first_alarm_hours_reg;
      `RCA_OFS_A1_DD:   value = first_alarm_daydate_reg;
      `RCA_OFS_A1_MON:  value = first_alarm_month_reg;
      `RCA_OFS_A1_YEAR: value = first_alarm_year_reg;
      default:          value = 8'h00;
    endcase
    return value;
  endfunction

  // Answer each request, sampling registers before that cycle's write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      read_data_reg <= 8'h00;
      ack_tog_reg   <= 1'b0;
    end else if (req_event) begin
      read_data_reg <= reg_read(req_reg.rd_addr);
      ack_tog_reg   <= ~ack_tog_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////

  // Per-field masked comparison
  always_comb begin
    logic       sec_hit;
    logic       min_hit;
    logic       hrs_hit;
    logic       day_hit;
    logic       mon_hit;
    logic       yr_hit;
    logic [7:0] day_target;
    day_target = 8'h00;
    sec_hit = first_alarm_seconds_reg[`RCA_BIT_MASK] ||
              ((first_alarm_seconds_reg & `RCA_FLD_SEC) == (tk_seconds & `RCA_FLD_SEC));
    min_hit = first_alarm_minutes_reg[`RCA_BIT_MASK] ||
              ((first_alarm_minutes_reg & `RCA_FLD_SEC) == (tk_minutes & `RCA_FLD_SEC));
    hrs_hit = first_alarm_hours_reg[`RCA_BIT_MASK] ||
              ((first_alarm_hours_reg & `RCA_FLD_HRS) == (tk_hours & `RCA_FLD_HRS));
    // Day of week or date of month
    if (first_alarm_daydate_reg[`RCA_BIT_DYDT]) begin
      day_target = calendar_weekday_reg & `RCA_FLD_WEEKDAY;
    end else begin
      day_target = calendar_date_reg & `RCA_FLD_DATE;
    end
    day_hit = first_alarm_daydate_reg[`RCA_BIT_MASK] ||
              ((first_alarm_daydate_reg & `RCA_FLD_DATE) == day_target);
    mon_hit = first_alarm_month_reg[`RCA_BIT_MASK] ||
              ((first_alarm_month_reg & `RCA_FLD_MONTH) ==
               (calendar_month_century_reg & `RCA_FLD_MONTH));
    yr_hit  = first_alarm_month_reg[`RCA_BIT_YR_MASK] ||
              (first_alarm_year_reg == calendar_year_reg);
    // Masked fields drop out, the rest must agree
    alarm_match = sec_hit && min_hit && hrs_hit && day_hit && mon_hit && yr_hit;
  end

  // Evaluate one cycle after the tick
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_delay_reg   <= 1'b0;
      alarm1_event_reg <= 1'b0;
      int_n_reg        <= 1'b1;
    end else begin
      tick_delay_reg   <= sec_tick;
      alarm1_event_reg <= tick_delay_reg && alarm_match;
      int_n_reg        <= ~(tick_delay_reg && alarm_match &&
                            int_enable_reg[`RCA_BIT_A1_IE]);
    end
  end

  ////////////////////////////////////////////////////////////////////////

  assign i2c_sda_out  = sda_out_reg;
  assign i2c_sda_oe   = sda_oe_reg;
  assign alarm1_event = alarm1_event_reg;
  assign int_n        = int_n_reg;

endmodule

`default_nettype wire

// ---- test/rca_top_chk.sv ----
`default_nettype none

module rca_top_chk (
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       i2c_scl,
  input wire logic       i2c_sda_in,
  input wire logic       i2c_sda_out,
  input wire logic       i2c_sda_oe,
  input wire logic       sec_tick,
  input wire logic [7:0] tk_seconds,
  input wire logic [7:0] tk_minutes,
  input wire logic [7:0] tk_hours,
  input wire logic       alarm1_event,
  input wire logic       int_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  ////////////////////////////////////////////////////////////////////////
  // Alarm pulse timing against the tick
  a_event_from_tick: assert property (alarm1_event |-> $past(sec_tick, 2))
    else $error("alarm pulse without a tick two cycles before");
  a_event_single: assert property (alarm1_event |=> !alarm1_event)
    else $error("alarm pulse longer than one cycle");
  a_quiet_no_tick: assert property (!sec_tick [*3] |=> !alarm1_event)
    else $error("alarm pulse between ticks");
  a_int_one_cycle: assert property (!int_n |=> int_n)
    else $error("interrupt pulse longer than one cycle");
  a_int_with_event: assert property (!int_n |-> alarm1_event)
    else $error("interrupt without alarm match");
  a_int_tick_delay: assert property (!int_n |-> $past(sec_tick, 2))
    else $error("interrupt not tied to a tick");

  ////////////////////////////////////////////////////////////////////////
  // Serial data pin only pulls low, and lets go when the link is idle
  a_sda_out_low: assert property (i2c_sda_oe |-> !i2c_sda_out)
    else $error("data pin driven high");
  a_bus_released: assert property ($stable(i2c_scl) [*8] |-> !i2c_sda_oe)
    else $error("data pin held while link idle");
endmodule

bind rca_top rca_top_chk chk (
  .core_clk     (core_clk),
  .rst_n        (rst_n),
  .i2c_scl      (i2c_scl),
  .i2c_sda_in   (i2c_sda_in),
  .i2c_sda_out  (i2c_sda_out),
  .i2c_sda_oe   (i2c_sda_oe),
  .sec_tick     (sec_tick),
  .tk_seconds   (tk_seconds),
  .tk_minutes   (tk_minutes),
  .tk_hours     (tk_hours),
  .alarm1_event (alarm1_event),
  .int_n        (int_n)
);

`default_nettype wire

// ---- test/rca_host.sv ----
`include "rca_cfg.svh"
`default_nettype none

module rca_host (
  output logic      scl,
  output logic      pull,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  int nacks;

  // Clock idles high, data released
  initial begin
    scl = 1'b1;
    pull = 1'b0;
    nacks = 0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Bit level, data moves mid low phase, 160 ns period
  task automatic put_bit(input logic b);
    #40 pull = ~b;
    #40 scl = 1'b1;
    #80 scl = 1'b0;
  endtask
  task automatic get_bit(output logic b);
    #40 pull = 1'b0;
    #40 scl = 1'b1;
    #40 b = sda;
    #40 scl = 1'b0;
  endtask
  // Start or repeated start, ends with clock low
  task automatic start();
    #40 pull = 1'b0;
    #40 scl = 1'b1;
    #40 pull = 1'b1;
    #40 scl = 1'b0;
  endtask
  // Clock then stands high
  task automatic stop();
    #40 pull = 1'b1;
    #40 scl = 1'b1;
    #40 pull = 1'b0;
  endtask
  task automatic send(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(a);
    if (a) nacks++;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Register write and pointer-then-read frames
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    start();
    send({`RCA_I2C_ADDR, 1'b0});
    send(ofs);
    send(d);
    stop();
  endtask
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
    start();
    send({`RCA_I2C_ADDR, 1'b0});
    send(ofs);
    start();
    send({`RCA_I2C_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(1'b1);
    stop();
  endtask
endmodule

`default_nettype wire

// ---- test/tb_rca_top.sv ----
`include "rca_cfg.svh"
`default_nettype none

module tb_rca_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CAL_WD = 8'h03;
  localparam logic [7:0] CAL_DATE = 8'h15;
  localparam logic [7:0] CAL_MON = 8'h86;
  localparam logic [7:0] CAL_YR = 8'h24;
  localparam logic [7:0] R_OFS [11] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h01};
  localparam logic [7:0] R_RST [11] = '{8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] R_RB [11] = '{8'h07, 8'h3f, 8'h9f, 8'hff, 8'hff, 8'hff, 8'h9f, 8'hff, 8'hdf, 8'hff, 8'h01};
  // Listed mask rows: bit 6 select, bits 5..0 year..seconds masks
  localparam logic [6:0] CFG [8] = '{7'h3f, 7'h3e, 7'h3c, 7'h38, 7'h30, 7'h20, 7'h00, 7'h70};
  logic       core_clk;
  logic       rst_n;
  logic       scl;
  logic       pull;
  logic       sda;
  logic       sda_out;
  logic       sda_oe;
  logic       sec_tick;
  logic [7:0] tk_seconds;
  logic [7:0] tk_minutes;
  logic [7:0] tk_hours;
  logic       alarm1_event;
  logic       int_n;
  logic [7:0] d;
  logic [7:0] a [6];
  logic [7:0] s;
  logic [7:0] m;
  logic [7:0] h;
  logic       off;
  logic       en;
  int         seed;
  int         fail_count;
  int         tests_run;
  int         ev_cnt;
  int         int_cnt;

  // Open-drain wire with pull-up
  assign sda = !((sda_oe && !sda_out) || pull);

  rca_top dut (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .i2c_scl      (scl),
    .i2c_sda_in   (sda),
    .i2c_sda_out  (sda_out),
    .i2c_sda_oe   (sda_oe),
    .sec_tick     (sec_tick),
    .tk_seconds   (tk_seconds),
    .tk_minutes   (tk_minutes),
    .tk_hours     (tk_hours),
    .alarm1_event (alarm1_event),
    .int_n        (int_n)
  );
  rca_host host (
    .scl  (scl),
    .pull (pull),
    .sda  (sda)
  );

  ////////////////////////////////////////////////////////////////////////
  // Clock, pulse counters, watchdog
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (alarm1_event === 1'b1) ev_cnt++;
    if (int_n === 1'b0) int_cnt++;
  end
  initial begin
    #3ms;
    fail_count++;
    give_verdict();
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction
  // Masked field compare against the fixed calendar
  function automatic logic hit(input logic [7:0] r [6], input logic [7:0] ts, tm, th);
    logic [5:0] dd;
    dd = r[3][6] ? {3'h0, CAL_WD[2:0]} : CAL_DATE[5:0];
    return (r[0][7] | (r[0][6:0] == ts[6:0])) & (r[1][7] | (r[1][6:0] == tm[6:0]))
      & (r[2][7] | (r[2][4:0] == th[4:0])) & (r[3][7] | (r[3][5:0] == dd))
      & (r[4][7] | (r[4][4:0] == CAL_MON[4:0])) & (r[4][6] | (r[5] == CAL_YR));
  endfunction
  // One tick, then count pulses in the answer window
  task automatic tick(input logic [7:0] ts, tm, th, input logic e);
    @(posedge core_clk);
    tk_seconds <= ts;
    tk_minutes <= tm;
    tk_hours <= th;
    sec_tick <= 1'b1;
    @(posedge core_clk);
    sec_tick <= 1'b0;
    ev_cnt = 0;
    int_cnt = 0;
    repeat (5) @(posedge core_clk);
    check("alarm event", 8'(ev_cnt), {7'h0, e});
    check("interrupt", 8'(int_cnt), {7'h0, e & en});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst_n = 1'b0;
    sec_tick = 1'b0;
    tk_seconds = 8'h00;
    tk_minutes = 8'h00;
    tk_hours = 8'h00;
    seed = 44;
    fail_count = 0;
    tests_run = 0;
    en = 1'b0;
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    tk_seconds <= 8'h42;
    #200;
    for (int i = 0; i < 11; i++) begin
      host.rd(R_OFS[i], d);
      check("reset value", d, R_RST[i]);
    end
    for (int i = 0; i < 11; i++) begin
      host.wr(R_OFS[i], 8'hff);
      host.rd(R_OFS[i], d);
      check("readback", d, R_RB[i]);
    end
    host.rd(8'h3f, d);
    check("unmapped read", d, 8'h00);
    host.rd(`RCA_OFS_TK_SEC, d);
    check("time readback", d, 8'h42);
    host.wr(`RCA_OFS_WEEKDAY, CAL_WD);
    host.wr(`RCA_OFS_DATE, CAL_DATE);
    host.wr(`RCA_OFS_MONTH, CAL_MON);
    host.wr(`RCA_OFS_YEAR, CAL_YR);
    for (int c = 0; c < 8; c++) begin
      off = 1'($random(seed));
      en = ~c[0];
      a[0] = {CFG[c][0], 7'(bcd($unsigned($random(seed)) % 60))};
      a[1] = {CFG[c][1], 7'(bcd($unsigned($random(seed)) % 60))};
      a[2] = {CFG[c][2], 2'h0, 5'(bcd($unsigned($random(seed)) % 20))};
      a[3] = {CFG[c][3], CFG[c][6], CFG[c][6] ? (off ? 6'h04 : 6'h03) : (off ? 6'h16 : 6'h15)};
      a[4] = {CFG[c][4], CFG[c][5], 1'b0, off ? 5'h07 : 5'h06};
      a[5] = off ? 8'h25 : 8'h24;
      for (int k = 0; k < 6; k++) host.wr(8'(8'h0d + k), a[k]);
      host.wr(`RCA_OFS_INT_EN, {7'h0, en});
      for (int t = 0; t < 6; t++) begin
        s = bcd($unsigned($random(seed)) % 60);
        m = bcd($unsigned($random(seed)) % 60);
        h = bcd($unsigned($random(seed)) % 20);
        if (t != 1) s = {1'b0, a[0][6:0]};
        if (t % 2 == 0) m = {1'b0, a[1][6:0]};
        if (t % 2 == 0) h = {3'h0, a[2][4:0]};
        tick(s, m, h, hit(a, s, m, h));
      end
    end
    check("host nacks", 8'(host.nacks), 8'h00);
    give_verdict();
  end
endmodule

`default_nettype wire
